// ===== rtl/tscd_core.sv
/*
 * Task status, global-register write guard and call depth counter of a core.
 * Registers sit on an AHB-Lite slave; the pipeline drives call, return,
 * interrupt-accept and global-register write strobes as one-cycle pulses.
 */
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Interrupt with stack select 0 loads stack pointer from interrupt stack pointer.
// - Interrupt with stack select 1 leaves the stack pointer alone.
// - Write permit 0 blocks writes to global address registers 0,1,8,9.
// - Write permit 1 lets writes to those global registers through.
// - Count enable 0 suspends counting; the next call sets it back to 1.
// - Count enable 1 counts unless the field encoding disables it.
// - All-ones depth field disables counting regardless of count enable.
// - Depth field is leading ones, a zero, then the count bits.
// - Active counting increments on call, decrements on return.
// - Prefix sets width 6 down to 0 bits; overflow raises a trap.
module tscd_core
   import tscd_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        call_exec,
   input  wire logic        ret_exec,
   input  wire logic        irq_accept,
   input  wire logic [31:0] cur_sp,
   input  wire logic        garw_req,
   input  wire logic [3:0]  garw_idx,
   output logic             sp_load_ff,
   output logic      [31:0] sp_value_ff,
   output logic             garw_grant_ff,
   output logic             depth_trap_ff,
   output logic             irq_ff
);
   logic [31:0] psw_ff;
   logic [31:0] isp_ff;
   logic [IRQ_W-1:0] stat_ff;
   logic [IRQ_W-1:0] mask_ff;
   logic        dwr_ff;
   logic [7:0]  daddr_ff;
   logic [31:0] nxt_hrdata;
   logic [6:0]  cdc_next;
   logic        ovf;
   logic        undf;
   logic        counting;
   logic        global_idx;
   logic        gw_block;
   logic        do_call;
   logic        do_ret;
   logic [IRQ_W-1:0] events;

   // Counting needs the enable bit and a field that is not all ones.
   assign counting = psw_ff[POS_CDE] &&
                     (psw_ff[CDC_W-1:0] != CDC_ALL_ONES);
   assign do_call  = call_exec && counting;
   assign do_ret   = ret_exec && counting && !call_exec;

   tscd_cdc_step u_step (
      .cdc_in    (psw_ff[CDC_W-1:0]),
      .do_call   (do_call),
      .do_ret    (do_ret),
      .cdc_out   (cdc_next),
      .overflow  (ovf),
      .underflow (undf)
   );

   // Only registers 0, 1, 8 and 9 are guarded.
   assign global_idx = (garw_idx == 4'h0) || (garw_idx == 4'h1) ||
                       (garw_idx == 4'h8) || (garw_idx == 4'h9);
   assign gw_block   = garw_req && global_idx && !psw_ff[POS_GW];

   assign events = {gw_block, undf, ovf};

   // Bus address phase is captured; the slave always answers with no wait states.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dwr_ff   <= 1'b0;
         daddr_ff <= 8'h00;
      end else if (hready) begin
         dwr_ff   <= hsel && htrans[1] && hwrite;
         daddr_ff <= haddr[7:0];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Read data mux; unmapped offsets read zero.
   always_comb begin
      nxt_hrdata = 32'h0000_0000;
      unique case (haddr[7:0])
         OFF_PSW:      nxt_hrdata = psw_ff;
         OFF_ISP:      nxt_hrdata = isp_ff;
         OFF_IRQ_STAT: nxt_hrdata = {29'h0, stat_ff};
         OFF_IRQ_MASK: nxt_hrdata = {29'h0, mask_ff};
         OFF_DEPTH:    nxt_hrdata = {31'h0, counting};
         default:      nxt_hrdata = 32'h0000_0000;
      endcase
   end

   // Read data is registered at the address phase so the data phase sees it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= nxt_hrdata;
      end
   end

   // Status word: software writes win over the pipeline in the same cycle,
   // except that reserved bits never change.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         psw_ff <= PSW_RESET;
      end else if (dwr_ff && daddr_ff == OFF_PSW) begin
         psw_ff <= hwdata & PSW_WMASK;
      end else begin
         if (do_call || do_ret) begin
            psw_ff[CDC_W-1:0] <= cdc_next;
         end
         if (call_exec && !psw_ff[POS_CDE]) begin
            psw_ff[POS_CDE] <= 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         isp_ff <= ISP_RESET;
      end else if (dwr_ff && daddr_ff == OFF_ISP) begin
         isp_ff <= hwdata;
      end
   end

   // Interrupt entry chooses the stack source for the service routine.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sp_load_ff  <= 1'b0;
         sp_value_ff <= 32'h0000_0000;
      end else begin
         sp_load_ff <= irq_accept;
         if (irq_accept) begin
            sp_value_ff <= psw_ff[POS_STACK_SEL] ? cur_sp
                                                 : isp_ff;
         end
      end
   end

   // Grant follows the request one cycle later.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         garw_grant_ff <= 1'b0;
         depth_trap_ff <= 1'b0;
      end else begin
         garw_grant_ff <= garw_req && (!global_idx || psw_ff[POS_GW]);
         depth_trap_ff <= ovf;
      end
   end

   // Sticky status: a new event beats a write-one clear in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_ff <= 3'h0;
      end else if (dwr_ff && daddr_ff == OFF_IRQ_STAT) begin
         stat_ff <= (stat_ff & ~hwdata[IRQ_W-1:0]) | events;
      end else begin
         stat_ff <= stat_ff | events;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_ff <= 3'h0;
      end else if (dwr_ff && daddr_ff == OFF_IRQ_MASK) begin
         mask_ff <= hwdata[IRQ_W-1:0];
      end
   end

   // Registered interrupt line lags the status by one cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(stat_ff & mask_ff);
      end
   end
endmodule : tscd_core
`default_nettype wire

// ===== rtl/tscd_pkg.sv
/*
 * Package for the task status and call depth block: register offsets, field positions,
 * reset values and the call depth field encodings.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package tscd_pkg;
   // Register byte offsets on the bus.
   localparam logic [7:0] OFF_PSW      = 8'h00;
   localparam logic [7:0] OFF_ISP      = 8'h04;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFF_DEPTH    = 8'h10;

   // Status word field positions.
   localparam int unsigned POS_STACK_SEL = 9;
   localparam int unsigned POS_GW        = 8;
   localparam int unsigned POS_CDE       = 7;
   localparam int unsigned CDC_W         = 7;

   // Status word reset value and writable bits.
   localparam logic [31:0] PSW_RESET = 32'h0000_0b80;
   localparam logic [31:0] PSW_WMASK = 32'hff00_7fff;
   localparam logic [31:0] ISP_RESET = 32'h0000_0000;

   // Call depth field with every bit set: counting disabled.
   localparam logic [6:0] CDC_ALL_ONES = 7'h7f;

   // Interrupt status bit positions.
   localparam int unsigned IRQ_OVF   = 0;
   localparam int unsigned IRQ_UNDF  = 1;
   localparam int unsigned IRQ_GWBLK = 2;
   localparam int unsigned IRQ_W     = 3;
endpackage : tscd_pkg

// ===== rtl/tscd_cdc_step.sv
/*
 * Call depth counter step: decodes the seven-bit prefix field and applies
 * one call or one return to the count subfield.
 * Assumes call and return are never both high; the caller gates enables.
 */
`timescale 1ns/10ps
`default_nettype none
module tscd_cdc_step
   import tscd_pkg::*;
(
   input  wire logic [6:0] cdc_in,
   input  wire logic       do_call,
   input  wire logic       do_ret,
   output logic      [6:0] cdc_out,
   output logic            overflow,
   output logic            underflow
);
   logic [6:0] cmask;
   logic [6:0] cnt;
   logic [6:0] cmax;

   // Count width is found by the first zero from the top; bits below it count.
   always_comb begin
      cmask = 7'h00;
      for (int i = 6; i >= 0; i--) begin
         if (cdc_in[i] == 1'b0 && cmask == 7'h00) begin
            cmask = 7'((32'h1 << i) - 1);
         end
      end
   end

   always_comb begin
      cnt       = cdc_in & cmask;
      cmax      = cmask;
      cdc_out   = cdc_in;
      overflow  = 1'b0;
      underflow = 1'b0;
      if (do_call) begin
         // Overflow wraps the count to zero and flags the trap.
         if (cnt == cmax) begin
            overflow = 1'b1;
            cdc_out  = cdc_in & ~cmask;
         end else begin
            cdc_out = (cdc_in & ~cmask) | (7'(cnt + 7'h01) & cmask);
         end
      end else if (do_ret) begin
         if (cnt == 7'h00) begin
            underflow = 1'b1;
            cdc_out   = cdc_in | cmask;
         end else begin
            cdc_out = (cdc_in & ~cmask) | (7'(cnt - 7'h01) & cmask);
         end
      end
   end
endmodule : tscd_cdc_step
`default_nettype wire

// ===== tb/tscd_core_sva.sv
/* Checker for the task status block: timing of its strobe outputs and its bus response.
   Assumes the single clock hclk and asynchronous active-low hresetn. */
`timescale 1ns/10ps
`default_nettype none
module tscd_core_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic call_exec,
   input wire logic ret_exec,
   input wire logic irq_accept,
   input wire logic garw_req,
   input wire logic sp_load_ff,
   input wire logic garw_grant_ff,
   input wire logic depth_trap_ff,
   input wire logic irq_ff
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Stack load answers each interrupt one cycle later; no strobe comes without its cause one cycle earlier.
   a_sp_load_follows: assert property (irq_accept |=> sp_load_ff)
      else $error("stack load missing");
   a_sp_load_cause: assert property (sp_load_ff |-> $past(irq_accept))
      else $error("stack load without interrupt");
   a_grant_cause: assert property (garw_grant_ff |-> $past(garw_req))
      else $error("grant without request");
   a_trap_cause: assert property (depth_trap_ff |-> $past(call_exec))
      else $error("trap without call");
   a_trap_single: assert property (depth_trap_ff |=> !depth_trap_ff)
      else $error("trap longer than one cycle");
   a_ret_no_trap: assert property (ret_exec && !call_exec |=> !depth_trap_ff)
      else $error("trap on return");
   a_idle_no_trap: assert property (!call_exec [*2] |-> !depth_trap_ff)
      else $error("trap while idle");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
   // Main scenarios reached.
   c_overflow: cover property (call_exec ##1 depth_trap_ff);
   c_blocked: cover property (garw_req ##1 !garw_grant_ff);
   c_irq: cover property ($rose(irq_ff));
endmodule : tscd_core_chk
bind tscd_core tscd_core_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
   .hresp(hresp), .call_exec(call_exec), .ret_exec(ret_exec), .irq_accept(irq_accept),
   .garw_req(garw_req), .sp_load_ff(sp_load_ff), .garw_grant_ff(garw_grant_ff),
   .depth_trap_ff(depth_trap_ff), .irq_ff(irq_ff));
`default_nettype wire

// ===== tb/test_task_status_stack_calldepth.sv
/* Self-checking bench for the task status block, driven over AHB-Lite.
   Assumes hready is the slave's own hreadyout, as with one slave. */
`timescale 1ns/10ps
`default_nettype none
module test_task_status_stack_calldepth;
   import tscd_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready;
   logic [31:0] haddr, hwdata, hrdata, cur_sp, sp_value_ff, q;
   logic [1:0]  htrans;
   logic [3:0]  ev, gidx;
   logic [6:0]  pre, mx;
   logic        hreadyout, hresp, sp_load_ff, garw_grant_ff, depth_trap_ff, irq_ff;
   int          fail_count, num_checks;
   logic [3:0]  gregs [4] = '{4'h0, 4'h1, 4'h8, 4'h9};
   assign hready = hreadyout;
   tscd_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .call_exec(ev[0]),
      .ret_exec(ev[1]), .irq_accept(ev[2]), .cur_sp(cur_sp), .garw_req(ev[3]),
      .garw_idx(gidx), .sp_load_ff(sp_load_ff), .sp_value_ff(sp_value_ff),
      .garw_grant_ff(garw_grant_ff), .depth_trap_ff(depth_trap_ff), .irq_ff(irq_ff));
   task automatic print_verdict;
      if (fail_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // One single transfer; read data is taken at the edge that ends the data phase.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   // One-cycle pulse on the event inputs; outputs are looked at once the next edge settles.
   task automatic strobe(input logic [3:0] m, input logic [3:0] idx);
      @(posedge hclk);
      ev <= m;
      gidx <= idx;
      @(posedge hclk);
      ev <= 4'h0;
      #1;
   endtask : strobe
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      print_verdict();
   end
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, ev, gidx} = '0;
      cur_sp = 32'h0000_8a40;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, OFF_PSW, 32'h0);
      check("psw", q, PSW_RESET);
      bus(1'b0, 8'h20, 32'h0);
      check("unmapped", q, 32'h0);
      strobe(4'h4, 4'h0);
      check("sp shared", sp_value_ff, 32'h0000_8a40);
      bus(1'b1, OFF_ISP, 32'h0000_7f00);
      bus(1'b1, OFF_PSW, 32'h0000_0980);
      strobe(4'h4, 4'h0);
      check("sp isp", {sp_value_ff[31:1], sp_load_ff}, 32'h0000_7f01);
      bus(1'b1, OFF_IRQ_MASK, 32'h4);
      // Permit set, then cleared: every global register follows the permit bit.
      for (int i = 0; i < 4; i++) begin
         strobe(4'h8, gregs[i]);
         check("grant on", {31'h0, garw_grant_ff}, 32'h1);
      end
      bus(1'b1, OFF_PSW, 32'h0000_0880);
      for (int i = 0; i < 4; i++) begin
         strobe(4'h8, gregs[i]);
         check("grant off", {31'h0, garw_grant_ff}, 32'h0);
      end
      @(posedge hclk);
      #1 check("irq", {31'h0, irq_ff}, 32'h1);
      bus(1'b1, OFF_IRQ_STAT, 32'h4);
      repeat (2) @(posedge hclk);
      #1 check("irq clr", {31'h0, irq_ff}, 32'h0);
      // Counter widths 1 to 6: step up, step down, then run over the top.
      for (int w = 1; w <= 6; w++) begin
         pre = 7'(7'h7f << (w + 1));
         mx = 7'((1 << w) - 1);
         bus(1'b1, OFF_PSW, {PSW_RESET[31:7], pre | (mx - 7'h1)});
         strobe(4'h1, 4'h0);
         bus(1'b0, OFF_PSW, 32'h0);
         check("cnt up", {25'h0, q[6:0]}, {25'h0, pre | mx});
         strobe(4'h2, 4'h0);
         bus(1'b0, OFF_PSW, 32'h0);
         check("cnt dn", {25'h0, q[6:0]}, {25'h0, pre | (mx - 7'h1)});
         strobe(4'h1, 4'h0);
         strobe(4'h1, 4'h0);
         check("trap", {31'h0, depth_trap_ff}, 32'h1);
         bus(1'b0, OFF_PSW, 32'h0);
         check("wrap", {25'h0, q[6:0]}, {25'h0, pre});
      end
      bus(1'b1, OFF_PSW, {PSW_RESET[31:7], CDC_ALL_ONES});
      strobe(4'h1, 4'h0);
      bus(1'b0, OFF_PSW, 32'h0);
      check("all ones", {25'h0, q[6:0]}, 32'h7f);
      bus(1'b1, OFF_PSW, 32'h0000_0b05);
      strobe(4'h1, 4'h0);
      bus(1'b0, OFF_PSW, 32'h0);
      check("suspend", {24'h0, q[7:0]}, 32'h85);
      strobe(4'h1, 4'h0);
      bus(1'b0, OFF_PSW, 32'h0);
      check("resume", {24'h0, q[7:0]}, 32'h86);
      bus(1'b0, OFF_DEPTH, 32'h0);
      check("counting", q, 32'h1);
      bus(1'b0, OFF_IRQ_STAT, 32'h0);
      check("ovf status", q, 32'h1);
      print_verdict();
   end
endmodule : test_task_status_stack_calldepth
`default_nettype wire
